// ==== design/wt_timer.sv ====
// watchdog timer with Avalon-MM register slave and refresh/sleep op inputs
// assumes ops come from the core on sys_clk as one-cycle pulses; reset_req_n
// feeds the chip reset logic which in turn asserts rst
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "wt_timer_consts.svh"
module wt_timer #(
   parameter int PRESC_DIV    = `WT_PRESC_DIV,
   parameter int FACTOR_STEP  = `WT_FACTOR_STEP,
   parameter int RESET_CYCLES = `WT_RESET_CYCLES
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // core instructions
   input  wire logic        watchdog_refresh_op,
   input  wire logic        watchdog_sleep_op,
   // outputs
   output logic             reset_req_n,
   output logic             wdog_active
);
   import wt_pkg::*;

   localparam int CW = `WT_CNT_W;
   localparam int RW = $clog2(RESET_CYCLES + 1);

   wt_pkg::wt_state_t state_r, state_nxt;

   logic [7:0]                 unlock_code_bits_r;
   logic [`WT_SELECT_W-1:0]    timeout_select_r;
   logic [CW-1:0]              tick_cnt_r;
   logic [CW-1:0]              limit;
   logic [RW-1:0]              rst_cnt_r;
   logic                       soft_mode;
   logic                       tick;
   logic                       expire;
   logic                       refresh_ok;
   logic                       sleep_ok;
   logic                       avs_req;
   logic                       avs_acc;
   logic                       wr_unlock;
   logic                       wr_select;
   logic [31:0]                rd_data;
   logic [31:0]                avs_readdata_r;
   logic                       avs_waitrequest_r;
   logic                       reset_req_n_r;
   logic                       wdog_active_r;

   assign avs_readdata    = avs_readdata_r;
   assign avs_waitrequest = avs_waitrequest_r;
   assign reset_req_n     = reset_req_n_r;
   assign wdog_active     = wdog_active_r;

   // ---------------- register bus ----------------
   // one wait cycle per access: waitrequest drops in the cycle after the request
   assign avs_req = avs_read || avs_write;
   assign avs_acc = avs_req && !avs_waitrequest_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         avs_waitrequest_r <= 1'b1;
      end else begin
         avs_waitrequest_r <= !(avs_req && avs_waitrequest_r);
      end
   end

   assign wr_unlock = avs_acc && avs_write && avs_byteenable[0]
                      && (avs_address == {`WT_IDX_UNLOCK, 2'b00});
   assign wr_select = avs_acc && avs_write && avs_byteenable[0]
                      && (avs_address == {`WT_IDX_SELECT, 2'b00});

   always_comb begin
      rd_data = 32'h00000000;
      unique case (avs_address)
         {`WT_IDX_UNLOCK, 2'b00}: rd_data[7:0] = unlock_code_bits_r;
         {`WT_IDX_SELECT, 2'b00}: rd_data[`WT_SELECT_W-1:0] = timeout_select_r;
         {`WT_IDX_STATUS, 2'b00}: begin
            rd_data[`WT_ST_ACTIVE]    = (state_r == WT_ST_RUN);
            rd_data[`WT_ST_SOFT]      = soft_mode;
            rd_data[`WT_ST_RESETTING] = (state_r == WT_ST_RESET);
            rd_data[`WT_ST_CNT_LSB +: CW] = tick_cnt_r;
         end
         default: rd_data = 32'h00000000;
      endcase
   end

   // data is latched in the wait cycle so it stands at the accepting edge
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         avs_readdata_r <= 32'h00000000;
      end else if (avs_read && avs_waitrequest_r) begin
         avs_readdata_r <= rd_data;
      end
   end

   // ---------------- configuration ----------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         unlock_code_bits_r <= `WT_UNLOCK_RST;
      end else if (wr_unlock) begin
         unlock_code_bits_r <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         timeout_select_r <= `WT_SELECT_RST;
      end else if (wr_select) begin
         timeout_select_r <= avs_writedata[`WT_SELECT_W-1:0];
      end
   end

   // any code but the unlock value keeps the unstoppable mode
   assign soft_mode = (unlock_code_bits_r == `WT_UNLOCK_CODE);

   // code 0 is a single tick, others step by the factor
   always_comb begin
      if (timeout_select_r == '0) begin
         limit = CW'(1);
      end else begin
         limit = CW'(FACTOR_STEP * int'(timeout_select_r));
      end
   end

   // ---------------- counting ----------------
   wt_prescaler #(
      .DIV     (PRESC_DIV)
   ) u_presc (
      .sys_clk (sys_clk),
      .rst     (rst),
      .run     (state_r == WT_ST_RUN),
      .clear   (refresh_ok),
      .tick    (tick)
   );

   // a refresh in the same cycle as sleep wins, so the core never loses protection
   assign refresh_ok = watchdog_refresh_op && (state_r != WT_ST_RESET);
   assign sleep_ok   = watchdog_sleep_op && soft_mode && !refresh_ok;
   // >= covers a select lowered while the count was already past it
   assign expire = (state_r == WT_ST_RUN) && tick && !refresh_ok
                   && (tick_cnt_r >= limit - CW'(1));

   always_ff @(posedge sys_clk) begin
      if (rst || refresh_ok || state_r != WT_ST_RUN) begin
         tick_cnt_r <= '0;
      end else if (tick) begin
         tick_cnt_r <= tick_cnt_r + CW'(1);
      end
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         WT_ST_RUN: begin
            if (expire) begin
               state_nxt = WT_ST_RESET;
            end else if (sleep_ok) begin
               state_nxt = WT_ST_STOP;
            end
         end
         WT_ST_STOP: begin
            // losing the unlock code makes the watchdog unstoppable again
            if (refresh_ok || !soft_mode) begin
               state_nxt = WT_ST_RUN;
            end
         end
         WT_ST_RESET: begin
            if (rst_cnt_r == RW'(RESET_CYCLES - 1)) begin
               state_nxt = WT_ST_RUN;
            end
         end
         default: state_nxt = WT_ST_RUN;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= WT_ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || state_r != WT_ST_RESET) begin
         rst_cnt_r <= '0;
      end else begin
         rst_cnt_r <= rst_cnt_r + RW'(1);
      end
   end

   // the reset request is held low for the whole reset cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reset_req_n_r <= 1'b1;
         wdog_active_r <= 1'b1;
      end else begin
         reset_req_n_r <= (state_nxt != WT_ST_RESET);
         wdog_active_r <= (state_nxt == WT_ST_RUN);
      end
   end

   // ---------------- checks ----------------
   sequence s_last_tick;
      (state_r == WT_ST_RUN) && tick && !watchdog_refresh_op
      && (tick_cnt_r == limit - CW'(1));
   endsequence

   sequence s_reset_low;
      (state_r == WT_ST_RESET) && !reset_req_n_r;
   endsequence

   a_expire_reset: assert property (@(posedge sys_clk) disable iff (rst)
      s_last_tick |=> s_reset_low ##1 (state_r == WT_ST_RESET || reset_req_n_r))
      else $error("expiry did not pull the reset request low");

   a_no_early_reset: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(reset_req_n_r) |-> $past(tick) && $past(tick_cnt_r) >= $past(limit) - CW'(1))
      else $error("reset request fell before the delay ran out");

   a_refresh_restart: assert property (@(posedge sys_clk) disable iff (rst)
      (watchdog_refresh_op && state_r != WT_ST_RESET)
      |=> (state_r == WT_ST_RUN) && (tick_cnt_r == '0) ##1 reset_req_n_r)
      else $error("refresh did not start or restart the watchdog");

   a_soft_sleep_stop: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == WT_ST_RUN && watchdog_sleep_op && !watchdog_refresh_op
       && unlock_code_bits_r == `WT_UNLOCK_CODE && !expire)
      |=> (state_r == WT_ST_STOP) && !wdog_active_r)
      else $error("sleep in software mode did not stop the watchdog");

   a_hard_sleep_ignored: assert property (@(posedge sys_clk) disable iff (rst)
      (unlock_code_bits_r != `WT_UNLOCK_CODE && state_r != WT_ST_RESET)
      |=> state_r != WT_ST_STOP)
      else $error("watchdog stopped while in hardware mode");

   a_after_reset: assert property (@(posedge sys_clk)
      rst |=> (state_r == WT_ST_RUN) && !soft_mode && reset_req_n_r && wdog_active_r)
      else $error("watchdog not enabled in hardware mode after reset");

   a_code_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (timeout_select_r == '0 && state_r == WT_ST_RUN && tick && !watchdog_refresh_op)
      |=> state_r == WT_ST_RESET)
      else $error("select code zero did not expire after one tick");

   a_count_step: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == WT_ST_RUN && tick && !watchdog_refresh_op && !expire)
      |=> tick_cnt_r == $past(tick_cnt_r) + CW'(1))
      else $error("tick counter did not advance by one per tick");

   a_select_write: assert property (@(posedge sys_clk) disable iff (rst)
      wr_select |=> timeout_select_r == $past(avs_writedata[3:0]))
      else $error("delay select did not take the low four bits");

endmodule : wt_timer
`default_nettype wire

// ==== design/wt_timer_consts.svh ====
// constants for the watchdog timer: register indices, fields, reset values, counts
// assumes a 10 MHz system clock and an Avalon-MM byte address of 8 bits
// Summary of operation
// - expiry without refresh forces full device reset
// - on expiry while active, drive reset low
// - refresh op starts idle or restarts running watchdog
// - software mode only for unlock byte AAh
// - software mode: sleep op stops the counter
// - hardware mode: sleep ignored, counting never stops
// - after reset: enabled, hardware mode
// - prescaler divides master clock by 500
// - low four select bits choose delay
// - timeout equals prescaler period times division factor
// - code zero gives factor one, else 625n
`ifndef WT_TIMER_CONSTS_SVH
`define WT_TIMER_CONSTS_SVH

// register indices; byte address is four times the index
`define WT_IDX_UNLOCK      6'h04
`define WT_IDX_SELECT      6'h07
`define WT_IDX_STATUS      6'h08

`define WT_UNLOCK_RST      8'h00
`define WT_UNLOCK_CODE     8'hAA
`define WT_SELECT_RST      4'h1
`define WT_SELECT_W        4

// status fields
`define WT_ST_ACTIVE       0
`define WT_ST_SOFT         1
`define WT_ST_RESETTING    2
`define WT_ST_CNT_LSB      16
`define WT_CNT_W           14

// timing
`define WT_PRESC_DIV       500
`define WT_FACTOR_STEP     625
`define WT_RESET_CYCLES    4

`endif

// ==== design/wt_pkg.sv ====
// types shared by the watchdog timer files
// assumes wt_timer_consts.svh for all numbers
package wt_pkg;

   typedef enum logic [2:0] {
      WT_ST_RUN   = 3'b001,
      WT_ST_STOP  = 3'b010,
      WT_ST_RESET = 3'b100
   } wt_state_t;

endpackage : wt_pkg

// ==== design/wt_prescaler.sv ====
// fixed divider making the one-cycle timeout tick enable
// assumes one clock; clear restarts a full division period
`timescale 1ns/10ps
`default_nettype none
module wt_prescaler #(
   parameter int DIV = 500
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // control
   input  wire logic run,
   input  wire logic clear,
   // tick
   output logic      tick
);
   import wt_pkg::*;

   localparam int CW = $clog2(DIV);

   logic [CW-1:0] div_cnt_r;
   logic [CW:0]   gap_r;

   assign tick = run && !clear && (div_cnt_r == CW'(DIV - 1));

   always_ff @(posedge sys_clk) begin
      if (rst || clear || !run || tick) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_r + 1'b1;
      end
   end

   // cycles since last tick or restart, seen only by the check below
   always_ff @(posedge sys_clk) begin
      if (rst || clear || !run || tick) begin
         gap_r <= '0;
      end else begin
         gap_r <= gap_r + 1'b1;
      end
   end

   a_tick_spacing: assert property (@(posedge sys_clk) disable iff (rst)
      tick |-> (gap_r == (CW+1)'(DIV - 1)))
      else $error("timeout tick spacing is not the division factor");

endmodule : wt_prescaler
`default_nettype wire

// ==== tb/wt_core_model.sv ====
// core model: issues refresh and sleep instructions as one-cycle pulses
// assumes the bench calls issue() from its own process, on sys_clk
`timescale 1ns/10ps
`default_nettype none
module wt_core_model (
   // clock
   input  wire logic sys_clk,
   // instructions
   output logic      watchdog_refresh_op,
   output logic      watchdog_sleep_op
);
   initial begin
      watchdog_refresh_op = 1'b0;
      watchdog_sleep_op   = 1'b0;
   end

   // the pulse is sampled at the edge on which the task returns
   task automatic issue(input logic refresh, input logic sleep);
      @(posedge sys_clk);
      watchdog_refresh_op <= refresh;
      watchdog_sleep_op   <= sleep;
      @(posedge sys_clk);
      watchdog_refresh_op <= 1'b0;
      watchdog_sleep_op   <= 1'b0;
   endtask : issue
endmodule : wt_core_model
`default_nettype wire

// ==== tb/watchdog_timer_test.sv ====
// self-checking bench for the watchdog timer: registers, timeouts, modes
// assumes shortened counts; the core model sits on the instruction inputs
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module watchdog_timer_test;
   localparam int PD = 5;
   localparam int FS = 3;
   localparam int RC = 2;
   logic        sys_clk         = 1'b0;
   logic        rst             = 1'b1;
   logic [7:0]  avs_address     = 8'h00;
   logic        avs_read        = 1'b0;
   logic        avs_write       = 1'b0;
   logic [31:0] avs_writedata   = 32'h0;
   logic [3:0]  avs_byteenable  = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        watchdog_refresh_op;
   logic        watchdog_sleep_op;
   logic        reset_req_n;
   logic        wdog_active;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   logic [7:0]  d;
   logic [31:0] seed            = 32'h5B9470CD;
   int          failures        = 0;
   int          n_tests         = 0;
   int          cyc             = 0;
   int          lows            = 0;
   int          n;

   always #50 sys_clk = ~sys_clk;

   wt_timer #(.PRESC_DIV(PD), .FACTOR_STEP(FS), .RESET_CYCLES(RC)) uut (
      .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .watchdog_refresh_op(watchdog_refresh_op),
      .watchdog_sleep_op(watchdog_sleep_op), .reset_req_n(reset_req_n),
      .wdog_active(wdog_active));

   wt_core_model core (.sys_clk(sys_clk), .watchdog_refresh_op(watchdog_refresh_op),
      .watchdog_sleep_op(watchdog_sleep_op));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat,
                      input logic [3:0] be);
      @(posedge sys_clk);
      avs_address    <= a;
      avs_writedata  <= dat;
      avs_byteenable <= be;
      avs_read       <= !wr;
      avs_write      <= wr;
      @(posedge sys_clk);
      while (avs_waitrequest) @(posedge sys_clk);
      avs_read       <= 1'b0;
      avs_write      <= 1'b0;
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      exp_q.push_back({m, x});
      bus(1'b0, a, 32'h0, 4'hF);
   endtask : rd

   // cycles from the current edge until reset request, then its length
   task automatic expire(input int x);
      n = 0;
      do begin @(posedge sys_clk); #1; n++; end while (reset_req_n);
      `CHK(n, x)
      n = 0;
      do begin @(posedge sys_clk); #1; n++; end while (!reset_req_n);
      `CHK(n, RC)
   endtask : expire

   // read data are taken at the accepting edge, oldest note first
   always @(posedge sys_clk) begin
      cyc++;
      if (!reset_req_n) lows++;
      if (avs_read && !avs_waitrequest) begin
         e = exp_q.pop_front();
         `CHK(avs_readdata & e[63:32], e[31:0])
      end
      if (cyc == 20000) begin
         failures++;
         give_verdict();
      end
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      rd(8'h1C, 32'hFFFFFFFF, 32'h1);
      // longest delay first so the start-up period cannot run out mid-sequence
      bus(1'b1, 8'h1C, 32'h0F, 4'hF);
      rd(8'h20, 32'h7, 32'h1);
      rd(8'h10, 32'hFFFFFFFF, 32'h0);
      bus(1'b1, 8'h00, 32'hAA, 4'hF);
      rd(8'h00, 32'hFFFFFFFF, 32'h0);
      bus(1'b1, 8'h10, 32'hAA, 4'h0);
      rd(8'h20, 32'h2, 32'h0);
      for (int c = 15; c >= 0; c--) begin
         bus(1'b1, 8'h1C, (xs() & 32'hFFFFFFF0) | 32'(c), 4'hF);
         rd(8'h1C, 32'hFFFFFFFF, 32'(c));
         while (!reset_req_n) @(posedge sys_clk);
         core.issue(1'b1, 1'b0);
         expire((c == 0) ? PD : PD * FS * c);
      end
      bus(1'b1, 8'h1C, 32'h1, 4'hF);
      core.issue(1'b1, 1'b0);
      core.issue(1'b0, 1'b1);
      @(posedge sys_clk);
      #1;
      `CHK(wdog_active, 1'b1)
      expire(PD * FS - 3);
      bus(1'b1, 8'h10, 32'hAA, 4'h1);
      rd(8'h20, 32'h7, 32'h3);
      core.issue(1'b0, 1'b1);
      @(posedge sys_clk);
      #1;
      `CHK(wdog_active, 1'b0)
      lows = 0;
      repeat (60) @(posedge sys_clk);
      `CHK(lows, 0)
      rd(8'h20, 32'hFFFFFFFF, 32'h2);
      core.issue(1'b1, 1'b0);
      expire(PD * FS);
      lows = 0;
      for (int i = 0; i < 20; i++) begin
         core.issue(1'b1, 1'b0);
         repeat (xs() % 10) @(posedge sys_clk);
      end
      `CHK(lows, 0)
      repeat (3) begin
         d = 8'(xs());
         bus(1'b1, 8'h10, {24'h0, (d == 8'hAA) ? 8'h55 : d}, 4'hF);
         rd(8'h20, 32'h2, 32'h0);
      end
      // a stopped watchdog must come back running after a chip reset
      bus(1'b1, 8'h10, 32'hAA, 4'hF);
      // refresh first so the sleep cannot meet an expiry left from the loop above
      core.issue(1'b1, 1'b0);
      core.issue(1'b0, 1'b1);
      @(posedge sys_clk);
      #1;
      `CHK(wdog_active, 1'b0)
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(8'h10, 32'hFF, 32'h0);
      rd(8'h20, 32'h7, 32'h1);
      // losing the unlock code while stopped must bring the count back
      bus(1'b1, 8'h10, 32'hAA, 4'hF);
      core.issue(1'b1, 1'b0);
      core.issue(1'b0, 1'b1);
      bus(1'b1, 8'h10, 32'h55, 4'hF);
      rd(8'h20, 32'h7, 32'h1);
      give_verdict();
   end
endmodule : watchdog_timer_test
`default_nettype wire
